// >>> rtl/hdpc_map.svh
`ifndef HDPC_MAP_SVH
`define HDPC_MAP_SVH

// Register indices; byte address is four times the index
`define HDPC_IDX_ATTACH 8'h48
`define HDPC_IDX_GATE 8'h49
`define HDPC_IDX_SPEED 8'h4A
`define HDPC_IDX_FORCE 8'h4B
`define HDPC_IDX_CTRL 8'h4C

// Reset values
`define HDPC_RST_ATTACH 4'h0
`define HDPC_RST_GATE 4'h0
`define HDPC_RST_SPEED 4'h0
`define HDPC_RST_FORCE 8'h00
`define HDPC_RST_CTRL 1'h0

// Control register field positions
`define HDPC_CTRL_IRQ_EN_BIT 0

// Forcing field codes, two bits per port
`define HDPC_FRC_NORMAL 2'h0
`define HDPC_FRC_DIFF1 2'h1
`define HDPC_FRC_DIFF0 2'h2
`define HDPC_FRC_SE0 2'h3

// Line states as {dp, dm}
`define HDPC_LINE_SE0 2'h0
`define HDPC_LINE_LSJ 2'h1
`define HDPC_LINE_FSJ 2'h2

// Timing, in nanoseconds as specified
`define HDPC_CLK_PERIOD_NS 8
`define HDPC_CONN_MIN_NS 2500
`define HDPC_DISC_MIN_NS 2000
`define HDPC_EOP_SE0_NS 167
`define HDPC_EOP_J_NS 84

// Cycle counts, least times rounded up
`define HDPC_CONN_CYC ((`HDPC_CONN_MIN_NS + `HDPC_CLK_PERIOD_NS - 1) / `HDPC_CLK_PERIOD_NS)
`define HDPC_DISC_CYC ((`HDPC_DISC_MIN_NS + `HDPC_CLK_PERIOD_NS - 1) / `HDPC_CLK_PERIOD_NS)
`define HDPC_EOP_SE0_CYC ((`HDPC_EOP_SE0_NS + `HDPC_CLK_PERIOD_NS - 1) / `HDPC_CLK_PERIOD_NS)
`define HDPC_EOP_J_CYC ((`HDPC_EOP_J_NS + `HDPC_CLK_PERIOD_NS - 1) / `HDPC_CLK_PERIOD_NS)

`endif

// >>> rtl/hdpc_pkg.sv
package hdpc_pkg;
    // Upstream repeat path states
    typedef enum logic [1:0] {
        up_idle,
        up_rpt,
        up_eop_se0,
        up_eop_j
    } hdpc_up_state_t;
endpackage

// >>> rtl/hdpc_top.sv
`include "hdpc_map.svh"

// Overview of operation
// - Low-speed attach sets connect bit, interrupts
// - Full-speed attach sets connect, clears speed
// - Connect needs non-SE0 longer than 2.5us
// - SE0 held 2.0us means disconnect, interrupt
// - Both lines low means nothing attached
// - Hub drives EOP upstream at EOF1 while repeating
// - Connect bits 3..0, clear on resets
// - Speed bits 3..0, one means low
// - Enabled port passes traffic both ways
// - Enabled port repeats upstream unless babbling
// - Low-speed ports never get full-speed traffic
// - Enabling waits for current packet end
// - Connect events interrupt even while suspended
// - Enable bits 3..0, cleared by resets
// - Babble at EOF2 clears port enable
// - Two-bit forcing field, zero is normal
// - Forced states use the port's edge rate
// - Codes: normal, diff one, diff zero, SE0
module hdpc_top
    import hdpc_pkg::*;
#(
    parameter int NPORT = 4
) (
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Hub-wide context
    input wire logic usb_bus_reset,
    input wire logic hub_suspend,
    input wire logic eof1,
    input wire logic eof2,
    // Upstream traffic heading downstream
    input wire logic us_tx_active,
    input wire logic us_tx_fs,
    input wire logic us_dp,
    input wire logic us_dm,
    // Downstream port pins
    input wire logic [NPORT-1:0] ds_dp_in,
    input wire logic [NPORT-1:0] ds_dm_in,
    output logic [NPORT-1:0] ds_dp_out,
    output logic [NPORT-1:0] ds_dm_out,
    output logic [NPORT-1:0] ds_oe,
    output logic [NPORT-1:0] ds_slow_edge,
    // Repeated traffic toward the upstream port
    output logic up_dp,
    output logic up_dm,
    output logic up_oe,
    // Hub interrupt to the processor
    output logic hub_irq
);
    localparam int CONN_CYC = `HDPC_CONN_CYC;
    localparam int DISC_CYC = `HDPC_DISC_CYC;
    localparam int CW = $clog2(CONN_CYC + 1);
    localparam int EW = 8;
    localparam int PW = $clog2(NPORT);

    // Bus slave state
    logic wr_pend_r; // Write data phase in progress
    logic rd_pend_r; // Read data phase in progress
    logic [7:0] idx_r; // Register index of the data phase
    logic hreadyout_r;
    logic [31:0] hrdata_r;
    logic addr_ok;
    logic [7:0] idx_nxt;
    logic [31:0] rd_val;

    // Registers
    logic [NPORT-1:0] attach_r; // Connect status
    logic [NPORT-1:0] speed_r; // One means low speed
    logic [NPORT-1:0] gate_r; // Port enabled
    logic [NPORT-1:0] pend_on_r; // Enable waiting for idle bus
    logic [2*NPORT-1:0] frc_r; // Forcing fields
    logic irq_en_r; // Hub interrupt enable
    logic wr_attach, wr_gate, wr_speed, wr_force, wr_ctrl;
    logic [NPORT-1:0] wd;

    // Per-port detection
    logic [1:0] line_r [NPORT]; // Sampled {dp, dm}
    logic [CW-1:0] flt_cnt_r [NPORT]; // Stable-line cycle count
    logic [NPORT-1:0] conn_ev, disc_ev, fs_line, babble, open, active_k;

    // Upstream path
    hdpc_up_state_t up_st_r;
    logic [PW-1:0] up_src_r;
    logic se0_seen_r;
    logic [EW-1:0] eop_cnt_r;
    logic up_dp_r, up_dm_r, up_oe_r;
    logic [PW-1:0] first_k;
    logic any_k;

    // Output registers
    logic [NPORT-1:0] ds_dp_r, ds_dm_r, ds_oe_r, ds_slow_r;
    logic hub_irq_r;

    // Address phase decode; unmapped or misaligned maps to an unused index
    assign addr_ok = hsel && hready && htrans[1];
    assign idx_nxt = (haddr[31:10] == 22'h0 && haddr[1:0] == 2'h0) ? haddr[9:2] : 8'hFF;

    // Bus phase tracking; reads take one wait state so data leave a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            idx_r <= 8'hFF;
            hreadyout_r <= 1'b1;
        end else begin
            wr_pend_r <= addr_ok && hwrite;
            rd_pend_r <= addr_ok && !hwrite;
            hreadyout_r <= !(addr_ok && !hwrite);
            if (addr_ok) begin
                idx_r <= idx_nxt;
            end
        end
    end

    // Register read mux; unused bits read zero
    always_comb begin
        rd_val = 32'h0;
        case (idx_r)
            `HDPC_IDX_ATTACH: rd_val[NPORT-1:0] = attach_r;
            `HDPC_IDX_GATE: rd_val[NPORT-1:0] = gate_r;
            `HDPC_IDX_SPEED: rd_val[NPORT-1:0] = speed_r;
            `HDPC_IDX_FORCE: rd_val[2*NPORT-1:0] = frc_r;
            `HDPC_IDX_CTRL: rd_val[`HDPC_CTRL_IRQ_EN_BIT] = irq_en_r;
            default: rd_val = 32'h0;
        endcase
    end

    // Read data captured in the wait cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0;
        end else if (rd_pend_r) begin
            hrdata_r <= rd_val;
        end
    end

    assign wr_attach = wr_pend_r && idx_r == `HDPC_IDX_ATTACH;
    assign wr_gate = wr_pend_r && idx_r == `HDPC_IDX_GATE;
    assign wr_speed = wr_pend_r && idx_r == `HDPC_IDX_SPEED;
    assign wr_force = wr_pend_r && idx_r == `HDPC_IDX_FORCE;
    assign wr_ctrl = wr_pend_r && idx_r == `HDPC_IDX_CTRL;
    assign wd = hwdata[NPORT-1:0];

    // Connect status; detected events win over a software write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            attach_r <= `HDPC_RST_ATTACH;
        end else if (usb_bus_reset) begin
            attach_r <= `HDPC_RST_ATTACH;
        end else begin
            attach_r <= ((wr_attach ? wd : attach_r) | conn_ev) & ~disc_ev;
        end
    end

    // Speed; firmware owns it except a full-speed attach or a reset clears it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            speed_r <= `HDPC_RST_SPEED;
        end else if (usb_bus_reset) begin
            speed_r <= `HDPC_RST_SPEED;
        end else begin
            speed_r <= (wr_speed ? wd : speed_r) & ~(conn_ev & fs_line);
        end
    end

    // Enable; turn-off is immediate, turn-on waits for an idle bus
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gate_r <= `HDPC_RST_GATE;
            pend_on_r <= `HDPC_RST_GATE;
        end else if (usb_bus_reset) begin
            gate_r <= `HDPC_RST_GATE;
            pend_on_r <= `HDPC_RST_GATE;
        end else begin
            gate_r <= ((wr_gate ? (gate_r & wd) : gate_r)
                       | (us_tx_active ? '0 : pend_on_r)) & ~babble;
            if (wr_gate) begin
                pend_on_r <= wd & ~gate_r & ~babble;
            end else if (!us_tx_active) begin
                pend_on_r <= '0;
            end else begin
                pend_on_r <= pend_on_r & ~babble;
            end
        end
    end

    // Forcing fields survive bus reset, cleared by chip reset only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frc_r <= `HDPC_RST_FORCE;
        end else if (wr_force) begin
            frc_r <= hwdata[2*NPORT-1:0];
        end
    end

    // Hub interrupt enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_en_r <= `HDPC_RST_CTRL;
        end else if (wr_ctrl) begin
            irq_en_r <= hwdata[`HDPC_CTRL_IRQ_EN_BIT];
        end
    end

    // Per-port line filter, detection and pin drive
    for (genvar i = 0; i < NPORT; i++) begin : g_port
        logic [1:0] frc;
        logic [1:0] idle_j;
        assign frc = frc_r[2*i +: 2];
        assign idle_j = speed_r[i] ? `HDPC_LINE_LSJ : `HDPC_LINE_FSJ;
        assign fs_line[i] = line_r[i] == `HDPC_LINE_FSJ;
        // Both lines low is the empty-port state
        assign conn_ev[i] = !attach_r[i] && line_r[i] != `HDPC_LINE_SE0
            && {ds_dp_in[i], ds_dm_in[i]} == line_r[i] && !ds_oe_r[i]
            && flt_cnt_r[i] == CW'(CONN_CYC - 1);
        assign disc_ev[i] = attach_r[i] && line_r[i] == `HDPC_LINE_SE0
            && {ds_dp_in[i], ds_dm_in[i]} == line_r[i] && !ds_oe_r[i]
            && flt_cnt_r[i] == CW'(DISC_CYC - 1);
        assign babble[i] = eof2 && gate_r[i]
            && (line_r[i] != idle_j || (up_st_r != up_idle && up_src_r == PW'(i)));
        assign open[i] = gate_r[i] && !hub_suspend && frc == `HDPC_FRC_NORMAL
            && !(speed_r[i] && us_tx_fs);
        assign active_k[i] = gate_r[i] && frc == `HDPC_FRC_NORMAL
            && line_r[i] != idle_j && line_r[i] != `HDPC_LINE_SE0;

        // Filter restarts on a line change, while we drive, or on bus reset so a
        // device still attached is found again; the line is held while we drive,
        // so our own echo is never mistaken for device traffic
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                line_r[i] <= `HDPC_LINE_SE0;
                flt_cnt_r[i] <= '0;
            end else begin
                if (!ds_oe_r[i]) begin
                    line_r[i] <= {ds_dp_in[i], ds_dm_in[i]};
                end
                if ({ds_dp_in[i], ds_dm_in[i]} != line_r[i] || ds_oe_r[i] || usb_bus_reset) begin
                    flt_cnt_r[i] <= '0;
                end else if (flt_cnt_r[i] != CW'(CONN_CYC)) begin
                    flt_cnt_r[i] <= flt_cnt_r[i] + CW'(1);
                end
            end
        end

        // Pin drive; forcing overrides repeating, edge rate follows speed
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                ds_dp_r[i] <= 1'b0;
                ds_dm_r[i] <= 1'b0;
                ds_oe_r[i] <= 1'b0;
                ds_slow_r[i] <= 1'b0;
            end else begin
                ds_slow_r[i] <= speed_r[i];
                case (frc)
                    `HDPC_FRC_DIFF1: begin
                        ds_oe_r[i] <= 1'b1;
                        ds_dp_r[i] <= 1'b1;
                        ds_dm_r[i] <= 1'b0;
                    end
                    `HDPC_FRC_DIFF0: begin
                        ds_oe_r[i] <= 1'b1;
                        ds_dp_r[i] <= 1'b0;
                        ds_dm_r[i] <= 1'b1;
                    end
                    `HDPC_FRC_SE0: begin
                        ds_oe_r[i] <= 1'b1;
                        ds_dp_r[i] <= 1'b0;
                        ds_dm_r[i] <= 1'b0;
                    end
                    default: begin
                        // Normal traffic toward the device
                        ds_oe_r[i] <= open[i] && us_tx_active;
                        ds_dp_r[i] <= us_dp;
                        ds_dm_r[i] <= us_dm;
                    end
                endcase
            end
        end
    end

    // Lowest port showing a K state claims the upstream path
    always_comb begin
        first_k = '0;
        any_k = 1'b0;
        for (int p = NPORT - 1; p >= 0; p--) begin
            if (active_k[p]) begin
                first_k = PW'(p);
                any_k = 1'b1;
            end
        end
    end

    // Upstream repeat path; outputs set together with the state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            up_st_r <= up_idle;
            up_src_r <= '0;
            se0_seen_r <= 1'b0;
            eop_cnt_r <= '0;
            up_oe_r <= 1'b0;
            up_dp_r <= 1'b1;
            up_dm_r <= 1'b0;
        end else begin
            case (up_st_r)
                up_idle: begin
                    up_oe_r <= 1'b0;
                    se0_seen_r <= 1'b0;
                    if (any_k && !us_tx_active && !hub_suspend && !usb_bus_reset) begin
                        up_st_r <= up_rpt;
                        up_src_r <= first_k;
                        up_oe_r <= 1'b1;
                        {up_dp_r, up_dm_r} <= line_r[first_k];
                    end
                end
                up_rpt: begin
                    {up_dp_r, up_dm_r} <= line_r[up_src_r];
                    if (line_r[up_src_r] == `HDPC_LINE_SE0) begin
                        se0_seen_r <= 1'b1;
                    end
                    if (eof1) begin
                        // Close a transfer still open at EOF1 with our own EOP
                        up_st_r <= up_eop_se0;
                        eop_cnt_r <= EW'(`HDPC_EOP_SE0_CYC - 1);
                        {up_dp_r, up_dm_r} <= `HDPC_LINE_SE0;
                    end else if (!gate_r[up_src_r] || usb_bus_reset) begin
                        up_st_r <= up_idle; // Babble or disable drops the path
                        up_oe_r <= 1'b0;
                    end else if (se0_seen_r && line_r[up_src_r] != `HDPC_LINE_SE0) begin
                        up_st_r <= up_idle;
                        up_oe_r <= 1'b0;
                    end
                end
                up_eop_se0: begin
                    if (eop_cnt_r == '0) begin
                        up_st_r <= up_eop_j;
                        eop_cnt_r <= EW'(`HDPC_EOP_J_CYC - 1);
                        {up_dp_r, up_dm_r} <= `HDPC_LINE_FSJ;
                    end else begin
                        eop_cnt_r <= eop_cnt_r - EW'(1);
                    end
                end
                up_eop_j: begin
                    if (eop_cnt_r == '0) begin
                        up_st_r <= up_idle;
                        up_oe_r <= 1'b0;
                    end else begin
                        eop_cnt_r <= eop_cnt_r - EW'(1);
                    end
                end
                default: begin
                    up_st_r <= up_idle;
                    up_oe_r <= 1'b0;
                end
            endcase
        end
    end

    // Hub interrupt pulse; suspend and port enable do not mask it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hub_irq_r <= 1'b0;
        end else begin
            hub_irq_r <= irq_en_r && |(conn_ev | disc_ev);
        end
    end

    assign hreadyout = hreadyout_r;
    assign hrdata = hrdata_r;
    assign hresp = 1'b0;
    assign ds_dp_out = ds_dp_r;
    assign ds_dm_out = ds_dm_r;
    assign ds_oe = ds_oe_r;
    assign ds_slow_edge = ds_slow_r;
    assign up_dp = up_dp_r;
    assign up_dm = up_dm_r;
    assign up_oe = up_oe_r;
    assign hub_irq = hub_irq_r;

    // Checks on the ports that carry traffic: 0 attaches, 1 is gated, 3 is forced
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn || usb_bus_reset);

    sequence s_up_se0;
        up_oe_r && !up_dp_r && !up_dm_r;
    endsequence

    sequence s_up_j;
        up_oe_r && up_dp_r && !up_dm_r;
    endsequence

    chk_conn_sets: assert property (conn_ev[0] |=> attach_r[0] && hub_irq_r == $past(irq_en_r))
        else $error("connect did not set status and interrupt");
    chk_fs_speed: assert property (conn_ev[0] && fs_line[0] |=> !speed_r[0])
        else $error("full speed connect left speed bit set");
    chk_conn_filter: assert property ($rose(attach_r[0]) && !$past(wr_attach)
        |-> $past(flt_cnt_r[0]) == CW'(CONN_CYC - 1) && $past(line_r[0]) != 2'h0)
        else $error("connect recorded before filter time");
    chk_disc_clears: assert property (disc_ev[0] |=> !attach_r[0] && hub_irq_r == $past(irq_en_r))
        else $error("disconnect not handled");
    chk_irq_cause: assert property (hub_irq_r |-> $past(conn_ev != '0 || disc_ev != '0))
        else $error("interrupt without port event");
    chk_attach_upper: assert property ($past(rd_pend_r && idx_r == `HDPC_IDX_ATTACH)
        |-> hrdata_r[31:NPORT] == '0 && hreadyout_r)
        else $error("status read upper bits not zero");
    chk_enable_waits: assert property (pend_on_r[1] && us_tx_active && !wr_gate |=> !gate_r[1])
        else $error("enable applied during a packet");
    chk_babble_off: assert property (babble[1] |=> !gate_r[1])
        else $error("babble left port enabled");
    chk_force_se0: assert property (frc_r[7:6] == `HDPC_FRC_SE0
        |=> ds_oe_r[3] && !ds_dp_r[3] && !ds_dm_r[3])
        else $error("forced SE0 not driven");
    chk_ls_withheld: assert property (us_tx_fs && speed_r[1] && frc_r[3:2] == 2'h0
        |=> !ds_oe_r[1])
        else $error("full speed traffic reached low speed port");
    chk_open_pass: assert property (open[1] && us_tx_active |=> ds_oe_r[1])
        else $error("enabled port not repeating");
    chk_eop_eof1: assert property (eof1 && up_st_r == up_rpt |=> s_up_se0 [*2] ##[1:30] s_up_j)
        else $error("no EOP upstream at EOF1");
endmodule // hdpc_top

// >>> verif/hdpc_dev_model.sv
// Four downstream devices, one two-bit mode per port
module hdpc_dev_model (
    input wire logic [7:0] dev_mode,
    input wire logic [3:0] ds_oe,
    input wire logic [3:0] ds_dp_out,
    input wire logic [3:0] ds_dm_out,
    output logic [3:0] ds_dp_in,
    output logic [3:0] ds_dm_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // Wire level per port: the hub wins while it drives, else the device bias
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (ds_oe[i]) begin
                // Hub drive seen back on its own inputs
                ds_dp_in[i] = ds_dp_out[i];
                ds_dm_in[i] = ds_dm_out[i];
            end else begin
                case (dev_mode[2*i+:2])
                    // Low-speed device, pull-up on the minus line
                    2'h1: {ds_dp_in[i], ds_dm_in[i]} = 2'h1;
                    // Full-speed device or a low-speed K, plus line high
                    2'h2: {ds_dp_in[i], ds_dm_in[i]} = 2'h2;
                    // Nothing attached, the pull-downs win
                    default: {ds_dp_in[i], ds_dm_in[i]} = 2'h0;
                endcase
            end
        end
    end
endmodule // hdpc_dev_model

// >>> verif/testbench.sv
`include "hdpc_map.svh"

module testbench;
    import hdpc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // Byte addresses, four times the register index
    localparam logic [31:0] A_ATT = {22'h0, `HDPC_IDX_ATTACH, 2'h0};
    localparam logic [31:0] A_GATE = {22'h0, `HDPC_IDX_GATE, 2'h0};
    localparam logic [31:0] A_SPD = {22'h0, `HDPC_IDX_SPEED, 2'h0};
    localparam logic [31:0] A_FRC = {22'h0, `HDPC_IDX_FORCE, 2'h0};
    localparam logic [31:0] A_CTL = {22'h0, `HDPC_IDX_CTRL, 2'h0};

    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic usb_bus_reset, hub_suspend, eof1, eof2, us_tx_active, us_tx_fs, us_dp, us_dm;
    logic [3:0] ds_dp_in, ds_dm_in, ds_dp_out, ds_dm_out, ds_oe, ds_slow_edge;
    logic up_dp, up_dm, up_oe, hub_irq;
    logic [7:0] dev_mode; // Two bits per port: none, low speed, full speed or K
    logic [31:0] rd; // Last read data
    int n_fail = 0;
    int samples_checked = 0;
    int cyc = 0; // Cycle count for the hang guard
    int n;

    hdpc_top i_hdpc_top (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .usb_bus_reset(usb_bus_reset), .hub_suspend(hub_suspend), .eof1(eof1), .eof2(eof2),
        .us_tx_active(us_tx_active), .us_tx_fs(us_tx_fs), .us_dp(us_dp), .us_dm(us_dm),
        .ds_dp_in(ds_dp_in), .ds_dm_in(ds_dm_in), .ds_dp_out(ds_dp_out),
        .ds_dm_out(ds_dm_out), .ds_oe(ds_oe), .ds_slow_edge(ds_slow_edge),
        .up_dp(up_dp), .up_dm(up_dm), .up_oe(up_oe), .hub_irq(hub_irq)
    );

    hdpc_dev_model i_hdpc_dev_model (
        .dev_mode(dev_mode), .ds_oe(ds_oe), .ds_dp_out(ds_dp_out), .ds_dm_out(ds_dm_out),
        .ds_dp_in(ds_dp_in), .ds_dm_in(ds_dm_in)
    );

    // Clock at 125 MHz
    initial begin
        hclk = 1'h0;
        forever #4 hclk = ~hclk;
    end

    // Compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask

    // One single AHB transfer; waits on hready, never on a fixed count
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'h1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        rd = hrdata;
    endtask

    // Read and compare
    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        bus(1'h0, a, 32'h0);
        check(rd, exp);
    endtask

    // Edges until the interrupt pulse, which must land inside lo..hi
    task automatic wait_irq(input int lo, input int hi);
        n = 0;
        while (hub_irq !== 1'h1 && n < hi + 10) begin
            @(posedge hclk);
            n++;
        end
        check(32'(n >= lo && n <= hi), 32'h1);
    endtask

    // One cycle end-of-frame marker
    task automatic pulse_eof2;
        eof2 <= 1'h1;
        @(posedge hclk);
        eof2 <= 1'h0;
    endtask

    // Reset values, reserved bits and an unmapped word
    task automatic t_regs;
        rdc(A_ATT, 32'h0);
        rdc(A_SPD, 32'h0);
        rdc(A_GATE, 32'h0);
        rdc(A_FRC, 32'h0);
        rdc(32'h140, 32'h0);
        check(32'(hresp), 32'h0);
        bus(1'h1, A_ATT, 32'hF0);
        rdc(A_ATT, 32'h0);
        // Firmware marks every port low speed before resetting it
        bus(1'h1, A_SPD, 32'hFF);
        rdc(A_SPD, 32'hF);
        bus(1'h1, A_CTL, 32'h1);
        $display("test regs done");
    endtask

    // Full-speed attach on port 0, then low-speed attach on port 1
    task automatic t_conn;
        dev_mode <= 8'h02;
        wait_irq(313, 319);
        rdc(A_ATT, 32'h1);
        rdc(A_SPD, 32'hE);
        dev_mode <= 8'h06;
        wait_irq(313, 319);
        rdc(A_ATT, 32'h3);
        rdc(A_SPD, 32'hE);
        // Port 0 unplugged; the pull-downs give SE0
        dev_mode <= 8'h04;
        wait_irq(250, 256);
        rdc(A_ATT, 32'h2);
        $display("test connect done");
    endtask

    // Enable pends across a packet; speed gating of repeated traffic
    task automatic t_gate;
        us_tx_active <= 1'h1;
        bus(1'h1, A_GATE, 32'h2);
        repeat (4) @(posedge hclk);
        check(32'(ds_oe[1]), 32'h0);
        us_tx_active <= 1'h0;
        repeat (3) @(posedge hclk);
        rdc(A_GATE, 32'h2);
        us_tx_active <= 1'h1;
        us_tx_fs <= 1'h1;
        repeat (4) @(posedge hclk);
        check(32'(ds_oe[1]), 32'h0);
        us_tx_active <= 1'h0;
        repeat (3) @(posedge hclk);
        us_tx_active <= 1'h1;
        us_tx_fs <= 1'h0;
        repeat (4) @(posedge hclk);
        check(32'(ds_oe[1]), 32'h1);
        us_tx_active <= 1'h0;
        $display("test gate done");
    endtask

    // Idle port survives EOF2; a port still sending K loses its enable
    task automatic t_babble;
        pulse_eof2;
        repeat (2) @(posedge hclk);
        rdc(A_GATE, 32'h2);
        dev_mode <= 8'h08;
        repeat (4) @(posedge hclk);
        check(32'(up_oe), 32'h1);
        // EOF1 while repeating: the hub closes the transfer with SE0
        eof1 <= 1'h1;
        @(posedge hclk);
        eof1 <= 1'h0;
        repeat (3) @(posedge hclk);
        check({up_oe, up_dp, up_dm}, 32'h4);
        pulse_eof2;
        repeat (2) @(posedge hclk);
        rdc(A_GATE, 32'h0);
        dev_mode <= 8'h04;
        $display("test babble done");
    endtask

    // Every forcing code on disabled port 3, then a bus reset
    task automatic t_force;
        for (int c = 0; c < 4; c++) begin
            bus(1'h1, A_FRC, 32'(c) << 6);
            repeat (3) @(posedge hclk);
            check(32'(ds_oe[3]), 32'(c != 0));
            if (c != 0) begin
                check({ds_dp_out[3], ds_dm_out[3]}, (c == 1) ? 2 : (c == 2) ? 1 : 0);
            end
        end
        check(32'(ds_slow_edge[3]), 32'h1);
        bus(1'h1, A_FRC, 32'h40);
        usb_bus_reset <= 1'h1;
        repeat (2) @(posedge hclk);
        usb_bus_reset <= 1'h0;
        rdc(A_ATT, 32'h0);
        rdc(A_SPD, 32'h0);
        rdc(A_GATE, 32'h0);
        rdc(A_FRC, 32'h40);
        // Forcing is cleared before any suspend
        bus(1'h1, A_FRC, 32'h0);
        // Suspended, disabled port 1 is found again after bus reset
        hub_suspend <= 1'h1;
        wait_irq(250, 319);
        rdc(A_ATT, 32'h2);
        $display("test force done");
    endtask

    // Counts, verdict and the end of the run
    task automatic results;
        $display("checked %0d samples, %0d mismatches", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Hang guard; the tests need under two thousand cycles
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            results;
        end
    end

    // Main sequence
    initial begin
        hresetn = 1'h0;
        hsel = 1'h0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        {usb_bus_reset, hub_suspend, eof1, eof2, us_tx_active, us_tx_fs} = 6'h0;
        us_dp = 1'h1;
        us_dm = 1'h0;
        dev_mode = 8'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        t_regs;
        t_conn;
        t_gate;
        t_babble;
        t_force;
        results;
    end
endmodule // testbench
